// file: strap_loader_regs.svh
// Purpose : Constants for the pin-strap configuration loader.
// Assumes : 10 MHz clock; eight strap inputs; four drive outputs.
// Notes   : Each strap input decodes to one of seven codes, BAD included.
`ifndef STRAP_LOADER_REGS_SVH
`define STRAP_LOADER_REGS_SVH

// Number of strap inputs and pattern drive outputs
`define STRAP_NUM          8
`define STRAP_DRV_NUM      4
// Pattern step length in cycles and number of steps
`define STRAP_STEP_CYC     4'h4
`define STRAP_STEPS        4'h8
// Strap codes
`define STRAP_CODE_LOW     3'h0
`define STRAP_CODE_HIGH    3'h1
`define STRAP_CODE_DRV_A   3'h2
`define STRAP_CODE_DRV_B   3'h3
`define STRAP_CODE_DRV_C   3'h4
`define STRAP_CODE_DRV_D   3'h5
`define STRAP_CODE_BAD     3'h7
// Reset value of latched configuration
`define STRAP_CFG_RST      24'h00_0000

`endif

// file: strap_loader_pkg.sv
// Purpose : Types for the pin-strap configuration loader.
// Assumes : Used by the loader top only; the classifier takes the _regs header alone.
// Notes   : Constants live in the _regs header.
package strap_loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DRIVE = 3'b010,
        ST_DONE  = 3'b100
    } phase_t;
endpackage

// file: strap_classifier.sv
// Purpose : Classifies one strap input against the drive patterns.
// Assumes : Pin synchronised upstream; sample strobe once per step.
// Notes   : A pattern match needs every step to agree.
`timescale 1ns/1ps
`include "strap_loader_regs.svh"
module strap_classifier (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_start,
    input  wire logic                      i_sample,
    input  wire logic                      i_pin,
    input  wire logic [`STRAP_DRV_NUM-1:0] i_drive,
    output logic      [2:0]                o_code
);
    ////////////////////////////////////////////////////////////////////////////
    // Match trackers: one per candidate source
    logic                      seen_low_ff;   // Pin ever low
    logic                      seen_high_ff;  // Pin ever high
    logic [`STRAP_DRV_NUM-1:0] match_ff;      // Pin equal to drive so far
    logic [`STRAP_DRV_NUM-1:0] nxt_match;
    wire  [`STRAP_DRV_NUM-1:0] eq_drive = i_drive ^ {`STRAP_DRV_NUM{~i_pin}};

    assign nxt_match = i_start ? {`STRAP_DRV_NUM{1'b1}} : (match_ff & eq_drive);

    // Trackers restart at the start of each analysis phase
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seen_low_ff  <= 1'b0;
            seen_high_ff <= 1'b0;
            match_ff     <= '0;
        end else if (i_start || i_sample) begin
            seen_low_ff  <= ~i_start & (seen_low_ff | ~i_pin);
            seen_high_ff <= ~i_start & (seen_high_ff | i_pin);
            match_ff     <= nxt_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority: constant levels first, since patterns always toggle
    always_comb begin
        if (!seen_high_ff)
            o_code = `STRAP_CODE_LOW;
        else if (!seen_low_ff)
            o_code = `STRAP_CODE_HIGH;
        else if (match_ff[0])
            o_code = `STRAP_CODE_DRV_A;
        else if (match_ff[1])
            o_code = `STRAP_CODE_DRV_B;
        else if (match_ff[2])
            o_code = `STRAP_CODE_DRV_C;
        else if (match_ff[3])
            o_code = `STRAP_CODE_DRV_D;
        else
            o_code = `STRAP_CODE_BAD;  // Noisy or shorted pin
    end
endmodule

// file: strap_config_loader.sv
// Purpose : Pin-strap configuration loader with alarm and lock outputs.
// Assumes : 10 MHz i_clk; strap and reset pins asynchronous.
// Notes   : Decoded fields are raw strap-code pairs; mapping is outside.
`timescale 1ns/1ps
`include "strap_loader_regs.svh"
module strap_config_loader (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_system_reset_n,
    input  wire logic [`STRAP_NUM-1:0] i_strap_in,
    input  wire logic                  i_ref_a_fail,
    input  wire logic                  i_ref_b_fail,
    input  wire logic                  i_ref_b_selected,
    input  wire logic                  i_phase_err,
    output logic                       o_ref_a_alarm_strap_a,
    output logic                       o_ref_b_alarm_strap_b,
    output logic                       o_strap_drive_out_c,
    output logic                       o_selected_ref_alarm_strap_d,
    output logic                       o_lock_indicator,
    output logic                       o_config_done,
    output logic [5:0]                 o_rate_set_sel,
    output logic [5:0]                 o_in_div_pad12_sel,
    output logic [5:0]                 o_sync_edge_out34_sel,
    output logic [5:0]                 o_odd_div_lock_pad34_sel,
    output logic [2:0]                 o_drive_c_code
);
    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers on the pins; a change counts on 2/3 agree
    logic [`STRAP_NUM-1:0] s1_ff, s2_ff, s3_ff, strap_ff;
    logic [2:0]            r_ff;              // Reset pin stages
    logic                  rst_n_ff;          // Filtered reset level
    logic [2:0]            a_ff, b_ff, sel_ff, pe_ff;
    logic                  a_fail_ff, b_fail_ff, sel_b_ff, perr_ff;

    // Pin sampling, filtered levels update only when stages agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            strap_ff <= '0;
            r_ff     <= '0;
            rst_n_ff <= 1'b0;
            a_ff     <= '0;
            b_ff     <= '0;
            sel_ff   <= '0;
            pe_ff    <= '0;
            a_fail_ff <= 1'b0;
            b_fail_ff <= 1'b0;
            sel_b_ff <= 1'b0;
            perr_ff  <= 1'b0;
        end else begin
            s1_ff <= i_strap_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // Stages 2 and 3 agree: take their level; they differ: hold.
            // A level that only one stage has seen never reaches the
            // classifiers, so a slow pin edge counts once
            strap_ff <= (strap_ff & (s2_ff ^ s3_ff)) | (s2_ff & (s2_ff ~^ s3_ff));
            r_ff   <= {r_ff[1:0], i_system_reset_n};
            a_ff   <= {a_ff[1:0], i_ref_a_fail};
            b_ff   <= {b_ff[1:0], i_ref_b_fail};
            sel_ff <= {sel_ff[1:0], i_ref_b_selected};
            pe_ff  <= {pe_ff[1:0], i_phase_err};
            if (r_ff[1] == r_ff[2])   rst_n_ff  <= r_ff[1];
            if (a_ff[1] == a_ff[2])   a_fail_ff <= a_ff[1];
            if (b_ff[1] == b_ff[2])   b_fail_ff <= b_ff[1];
            if (sel_ff[1] == sel_ff[2]) sel_b_ff <= sel_ff[1];
            if (pe_ff[1] == pe_ff[2]) perr_ff   <= pe_ff[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequencer: power-up lands in IDLE, then analysis starts
    strap_loader_pkg::phase_t state_ff, nxt_state;
    logic [3:0] cyc_ff;     // Cycles within a pattern step
    logic [3:0] step_ff;    // Pattern step index
    logic       latch_ff;   // Strobe one cycle after the last compare

    wire step_end   = (cyc_ff == `STRAP_STEP_CYC - 4'h1);
    // One lead-in step ahead of the eight compared ones, see the pattern delay
    wire last_step  = (step_ff == `STRAP_STEPS);
    wire start      = (state_ff == strap_loader_pkg::ST_IDLE) && rst_n_ff;
    // Step boundary while analysing; advances the step counter
    wire sample     = (state_ff == strap_loader_pkg::ST_DRIVE) && step_end;
    // Pins are compared from the second boundary on: the first one sees
    // only what the pins showed before the analysis began
    wire take       = sample && (step_ff != 4'h0);
    wire finish     = sample && last_step;

    // Next phase; a held system reset sends us back to IDLE
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            strap_loader_pkg::ST_IDLE: begin
                if (rst_n_ff) nxt_state = strap_loader_pkg::ST_DRIVE;
            end
            strap_loader_pkg::ST_DRIVE: begin
                if (!rst_n_ff)   nxt_state = strap_loader_pkg::ST_IDLE;
                else if (finish) nxt_state = strap_loader_pkg::ST_DONE;
            end
            strap_loader_pkg::ST_DONE: begin
                if (!rst_n_ff) nxt_state = strap_loader_pkg::ST_IDLE;
            end
            default: nxt_state = strap_loader_pkg::ST_IDLE;
        endcase
    end

    // Phase state and step counters
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= strap_loader_pkg::ST_IDLE;
            cyc_ff   <= 4'h0;
            step_ff  <= 4'h0;
            latch_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            latch_ff <= finish;
            cyc_ff   <= (start || step_end) ? 4'h0 : cyc_ff + 4'h1;
            if (start)       step_ff <= 4'h0;
            else if (sample) step_ff <= step_ff + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Distinct patterns: a and b toggle on step bits 0 and 1, c is b inverted and d
    // is bits 0 and 2 xored, so constant straps see no toggling and outputs differ pairwise
    wire [`STRAP_DRV_NUM-1:0] drive_pat = {
        step_ff[0] ^ step_ff[2],          // d
        ~step_ff[1],                       // c
        step_ff[1],                        // b
        step_ff[0]                         // a
    };

    ////////////////////////////////////////////////////////////////////////////
    // Pattern delay: the pin path lags the step counter by five cycles
    // (output flop, three sync stages, agree filter), one more than a step.
    // What a pin shows during step n is therefore steady at the end of
    // step n+1, so each compare uses the pattern of the step before.
    // Trade-off: one extra step of analysis instead of a longer step.
    logic [`STRAP_DRV_NUM-1:0] pat_ff;   // Pattern of the previous step
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pat_ff <= '0;
        end else if (sample) begin
            pat_ff <= drive_pat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One classifier per strap input
    // All eight share one pattern and one strobe, so several straps may
    // be wired to the same drive output and still decode alike
    logic [2:0] code [`STRAP_NUM];
    genvar gi;
    generate
        for (gi = 0; gi < `STRAP_NUM; gi++) begin : g_cls
            strap_classifier u_cls (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_start (start),
                .i_sample(take),
                .i_pin   (strap_ff[gi]),
                .i_drive (pat_ff),
                .o_code  (code[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Latched configuration, held until the next reset cycle
    logic [23:0] cfg_ff;
    logic        done_ff;
    logic [2:0]  drv_c_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_ff   <= `STRAP_CFG_RST;
            done_ff  <= 1'b0;
            drv_c_ff <= 3'h0;
        end else if (latch_ff) begin  // Trackers now hold the final compare
            cfg_ff   <= {code[7], code[6], code[5], code[4],
                         code[3], code[2], code[1], code[0]};
            done_ff  <= 1'b1;
            drv_c_ff <= code[2];
        end else if (start) begin
            done_ff  <= 1'b0;  // Old setup stays until the new one lands
        end
    end

    assign o_config_done            = done_ff;
    assign o_rate_set_sel           = cfg_ff[5:0];
    assign o_in_div_pad12_sel       = cfg_ff[11:6];
    assign o_sync_edge_out34_sel    = cfg_ff[17:12];
    assign o_odd_div_lock_pad34_sel = cfg_ff[23:18];
    // Code of strap input 2; resync and input rate use it
    assign o_drive_c_code           = drv_c_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Lock enable: strap pair six/seven both high disables the detector
    wire lock_off = (cfg_ff[20:18] == `STRAP_CODE_HIGH) &&
                    (cfg_ff[23:21] == `STRAP_CODE_HIGH);
    wire sel_fail = sel_b_ff ? b_fail_ff : a_fail_ff;
    wire cfg_phase = (state_ff != strap_loader_pkg::ST_DONE);

    // Output pins: patterns while configuring, alarms afterwards on a, b and d, c held low
    // Alarms lag their inputs by five cycles: four for the filter and one
    // for this flop. A failure lasting one cycle only is not reported,
    // which keeps a glitch on a reference from toggling the alarm pin.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ref_a_alarm_strap_a        <= 1'b0;
            o_ref_b_alarm_strap_b        <= 1'b0;
            o_strap_drive_out_c          <= 1'b0;
            o_selected_ref_alarm_strap_d <= 1'b0;
            o_lock_indicator             <= 1'b0;
        end else begin
            o_ref_a_alarm_strap_a <= cfg_phase ? drive_pat[0] : a_fail_ff;
            o_ref_b_alarm_strap_b <= cfg_phase ? drive_pat[1] : b_fail_ff;
            o_strap_drive_out_c   <= cfg_phase ? drive_pat[2] : 1'b0;
            o_selected_ref_alarm_strap_d <= cfg_phase ? drive_pat[3]
                                                      : sel_fail;
            o_lock_indicator <= (!cfg_phase && !lock_off) ? perr_ff : 1'b0;
        end
    end
endmodule

// file: strap_config_loader_asserts.sv
// Purpose : Port checker for the strap configuration loader.
// Assumes : Settled means done and 100 cycles past either reset.
// Notes   : Alarm checks wait for eight quiet input cycles.
`timescale 1ns/1ps
module strap_config_loader_asserts (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_system_reset_n,
    input wire logic       i_ref_a_fail,
    input wire logic       i_ref_b_fail,
    input wire logic       i_ref_b_selected,
    input wire logic       i_phase_err,
    input wire logic       o_ref_a_alarm_strap_a,
    input wire logic       o_ref_b_alarm_strap_b,
    input wire logic       o_strap_drive_out_c,
    input wire logic       o_selected_ref_alarm_strap_d,
    input wire logic       o_lock_indicator,
    input wire logic       o_config_done,
    input wire logic [5:0] o_rate_set_sel,
    input wire logic [5:0] o_in_div_pad12_sel,
    input wire logic [5:0] o_sync_edge_out34_sel,
    input wire logic [5:0] o_odd_div_lock_pad34_sel
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] cnt_ff;   // Cycles since the last reset of either kind
    wire        settled = o_config_done && (cnt_ff >= 8'h64);
    wire        lock_off = (o_odd_div_lock_pad34_sel == 6'h09);
    wire        sel_exp = i_ref_b_selected ? i_ref_b_fail : i_ref_a_fail;
    wire [23:0] setup = {o_rate_set_sel, o_in_div_pad12_sel,
                         o_sync_edge_out34_sel, o_odd_div_lock_pad34_sel};
    // Saturating count so settled never wraps back to false
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) cnt_ff <= 8'h00;
        else if (!i_system_reset_n) cnt_ff <= 8'h00;
        else if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_done_bound; cnt_ff == 8'h64 |-> o_config_done; endproperty
    a_done_bound: assert property (p_done_bound) else $error("setup late");
    property p_hold; settled && $past(settled) |-> $stable(setup); endproperty
    a_hold: assert property (p_hold) else $error("setup moved");
    property p_c_low; settled |-> !o_strap_drive_out_c; endproperty
    a_c_low: assert property (p_c_low) else $error("drive c active");
    property p_lock_off; settled && lock_off |-> !o_lock_indicator; endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock not low");
    property p_lock_on;
        (settled && !lock_off && i_phase_err)[*8] |-> o_lock_indicator;
    endproperty
    a_lock_on: assert property (p_lock_on) else $error("lock missing");
    property p_alarm_a;
        (settled && $stable(i_ref_a_fail))[*8] |-> o_ref_a_alarm_strap_a == i_ref_a_fail;
    endproperty
    a_alarm_a: assert property (p_alarm_a) else $error("alarm a wrong");
    property p_alarm_b;
        (settled && $stable(i_ref_b_fail))[*8] |-> o_ref_b_alarm_strap_b == i_ref_b_fail;
    endproperty
    a_alarm_b: assert property (p_alarm_b) else $error("alarm b wrong");
    property p_alarm_sel;
        (settled && $stable(sel_exp))[*8] |-> o_selected_ref_alarm_strap_d == sel_exp;
    endproperty
    a_alarm_sel: assert property (p_alarm_sel) else $error("alarm d wrong");
    c_done: cover property ($rose(o_config_done));
    c_lock_off: cover property (settled && lock_off);
    c_sel_alarm: cover property (settled && o_selected_ref_alarm_strap_d);
endmodule
bind strap_config_loader strap_config_loader_asserts u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_system_reset_n(i_system_reset_n),
    .i_ref_a_fail(i_ref_a_fail), .i_ref_b_fail(i_ref_b_fail),
    .i_ref_b_selected(i_ref_b_selected), .i_phase_err(i_phase_err),
    .o_ref_a_alarm_strap_a(o_ref_a_alarm_strap_a),
    .o_ref_b_alarm_strap_b(o_ref_b_alarm_strap_b),
    .o_strap_drive_out_c(o_strap_drive_out_c),
    .o_selected_ref_alarm_strap_d(o_selected_ref_alarm_strap_d),
    .o_lock_indicator(o_lock_indicator), .o_config_done(o_config_done),
    .o_rate_set_sel(o_rate_set_sel), .o_in_div_pad12_sel(o_in_div_pad12_sel),
    .o_sync_edge_out34_sel(o_sync_edge_out34_sel),
    .o_odd_div_lock_pad34_sel(o_odd_div_lock_pad34_sel));

// file: strap_board_wiring.sv
// Purpose : Board wiring of each strap pin to a level or drive output.
// Assumes : Three-bit wiring code per strap, same codes as the loader.
// Notes   : Unknown codes leave the pin to its pull-down.
`timescale 1ns/1ps
`include "strap_loader_regs.svh"
module strap_board_wiring (
    input  wire logic [23:0] i_codes,
    input  wire logic        i_drv_a,
    input  wire logic        i_drv_b,
    input  wire logic        i_drv_c,
    input  wire logic        i_drv_d,
    output logic      [7:0]  o_strap_in
);
    // Each pin follows its tie or its drive output
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            case (i_codes[3*k +: 3])
                `STRAP_CODE_HIGH:  o_strap_in[k] = 1'b1;
                `STRAP_CODE_DRV_A: o_strap_in[k] = i_drv_a;
                `STRAP_CODE_DRV_B: o_strap_in[k] = i_drv_b;
                `STRAP_CODE_DRV_C: o_strap_in[k] = i_drv_c;
                `STRAP_CODE_DRV_D: o_strap_in[k] = i_drv_d;
                default:           o_strap_in[k] = 1'b0;    // Pull-down
            endcase
        end
    end
endmodule

// file: strap_config_loader_tb.sv
// Purpose : Self-checking bench for the strap configuration loader.
// Assumes : 10 MHz clock; straps wired by the board model.
// Notes   : Settle waits follow the loader's start and step figures.
`timescale 1ns/1ps
`include "strap_loader_regs.svh"
module strap_config_loader_tb;
    logic i_clk = 1'b0, i_rst = 1'b1, i_system_reset_n = 1'b1;
    logic i_ref_a_fail = 1'b0, i_ref_b_fail = 1'b0;
    logic i_ref_b_selected = 1'b0, i_phase_err = 1'b0;
    logic [23:0] codes = 24'h00_0000; // Board wiring codes
    logic [7:0] strap_in;
    logic a_o, b_o, c_o, d_o, lock_o, done_o;
    logic [5:0] rate_o, div_o, sync_o, odd_o;
    logic [2:0] c_code_o;
    int code[8];                   // Model of each strap's wiring
    int mismatches = 0, n_checks = 0, cyc = 0;
    always #50 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    strap_board_wiring u_strap_board_wiring (.i_codes(codes), .i_drv_a(a_o),
        .i_drv_b(b_o), .i_drv_c(c_o), .i_drv_d(d_o), .o_strap_in(strap_in));
    strap_config_loader u_strap_config_loader (.i_clk(i_clk), .i_rst(i_rst),
        .i_system_reset_n(i_system_reset_n), .i_strap_in(strap_in),
        .i_ref_a_fail(i_ref_a_fail), .i_ref_b_fail(i_ref_b_fail),
        .i_ref_b_selected(i_ref_b_selected), .i_phase_err(i_phase_err),
        .o_ref_a_alarm_strap_a(a_o), .o_ref_b_alarm_strap_b(b_o),
        .o_strap_drive_out_c(c_o), .o_selected_ref_alarm_strap_d(d_o),
        .o_lock_indicator(lock_o), .o_config_done(done_o),
        .o_rate_set_sel(rate_o), .o_in_div_pad12_sel(div_o),
        .o_sync_edge_out34_sel(sync_o), .o_odd_div_lock_pad34_sel(odd_o),
        .o_drive_c_code(c_code_o));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Mode 0 uses every wiring code, mode 1 disables lock, else random
    task automatic set_codes(input int mode);
        for (int k = 0; k < 8; k++) begin
            code[k] = (mode == 0) ? k % 6 : $urandom_range(5);
            if (mode == 1 && k > 5) code[k] = 1;
            codes[3*k +: 3] <= 3'(code[k]);
        end
    endtask
    task automatic check_setup();
        cmp(rate_o, 6'(code[1] * 8 + code[0]));
        cmp(div_o, 6'(code[3] * 8 + code[2]));
        cmp(sync_o, 6'(code[5] * 8 + code[4]));
        cmp(odd_o, 6'(code[7] * 8 + code[6]));
        cmp({3'h0, c_code_o}, 6'(code[2]));
        cmp({5'h00, done_o}, 6'h01);
    endtask
    // Random alarm and phase levels, held until the outputs settle
    task automatic check_run();
        logic lk_off, fa, fb, sb, pe;
        lk_off = (code[6] == 1) && (code[7] == 1);
        repeat (4) begin
            @(posedge i_clk);
            {fa, fb, sb, pe} = 4'($urandom);
            i_ref_a_fail <= fa;
            i_ref_b_fail <= fb;
            i_ref_b_selected <= sb;
            i_phase_err <= pe;
            repeat (10) @(posedge i_clk);
            @(negedge i_clk);
            cmp({5'h00, a_o}, {5'h00, fa});
            cmp({5'h00, b_o}, {5'h00, fb});
            cmp({5'h00, d_o}, {5'h00, sb ? fb : fa});
            cmp({5'h00, c_o}, 6'h00);
            cmp({5'h00, lock_o}, {5'h00, pe & !lk_off});
        end
    endtask
    // Cuts a hang short
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(53));
        set_codes(0);
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int w = 0; w < 200 && done_o !== 1'b1; w++) @(posedge i_clk);
        @(negedge i_clk);
        check_setup();
        check_run();
        for (int m = 1; m < 5; m++) begin
            @(posedge i_clk);
            i_system_reset_n <= 1'b0;
            set_codes(m);
            repeat (10) @(posedge i_clk);
            i_system_reset_n <= 1'b1;
            repeat (80) @(posedge i_clk);
            @(negedge i_clk);
            check_setup();
            check_run();
        end
        @(posedge i_clk);
        codes <= ~codes;
        repeat (60) @(posedge i_clk);
        @(negedge i_clk);
        check_setup();
        finish_test();
    end
endmodule
